// ===== logic/edge_irq_pkg.sv
// shared constants and carriers of the edge interrupt unit
package edge_irq_pkg;
  localparam int unsigned key_count = 8;
  localparam int unsigned ext_count = 3;
  localparam int unsigned addr_w = 4;

  // register offsets
  localparam logic [3:0] key_input_enable_off = 4'h0;
  localparam logic [3:0] key_edge_status_off = 4'h1;
  localparam logic [3:0] ext_irq_enable_clear_off = 4'h2;
  localparam logic [3:0] ext_irq_flags_off = 4'h3;
  localparam logic [3:0] irq_status_off = 4'h4;
  localparam logic [3:0] irq_mask_off = 4'h5;

  // field positions
  localparam int unsigned ext_en_lsb = 5;
  localparam int unsigned ext_test_bit = 4;
  localparam int unsigned ext_clr_lsb = 1;
  localparam int unsigned ext_flag_lsb = 1;

  // reset values
  localparam logic [7:0] key_enable_rst = 8'h00;
  localparam logic [2:0] ext_enable_rst = 3'h0;
  localparam logic [1:0] irq_mask_rst = 2'h0;
  localparam logic input_idle_rst = 1'b1;

  // summary status bit positions
  localparam int unsigned ev_key = 0;
  localparam int unsigned ev_ext = 1;

  typedef struct packed {
    logic [addr_w-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic key_req;
    logic [ext_count-1:0] ext_req;
    logic wake;
    logic irq;
  } irq_out_t;
endpackage

// ===== logic/fall_detect.sv
// synchronous falling edge detector for a group of inputs
`timescale 1ns/1ps
module fall_detect
  import edge_irq_pkg::*;
#(
  parameter int unsigned width = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [width-1:0] pin,
  output logic [width-1:0] fall
);
  typedef struct packed {
    logic [width-1:0] prev;
  } fd_state_t;

  fd_state_t st_q;
  fd_state_t st_d;

  // idle high so that reset release alone gives no edge
  always_comb begin
    st_d = st_q;
    st_d.prev = pin;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q.prev <= {width{input_idle_rst}};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign fall = st_q.prev & ~pin;
endmodule

// ===== logic/flag_bank.sv
// sticky edge flags with set winning over clear
`timescale 1ns/1ps
module flag_bank
#(
  parameter int unsigned width = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [width-1:0] set,
  input wire logic [width-1:0] clr,
  output logic [width-1:0] flags
);
  typedef struct packed {
    logic [width-1:0] f;
  } fb_state_t;

  fb_state_t st_q;
  fb_state_t st_d;

  always_comb begin
    st_d = st_q;
    // an edge in the clearing cycle is kept
    st_d.f = (st_q.f & ~clr) | set;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q.f <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.f;
endmodule

// ===== logic/edge_irq_unit.sv
// falling edge key and external interrupt unit with register port
//
// What this block does
// R01 - Eight key inputs each get a falling-edge detector, enable and flag.
// R02 - The key enable register holds one enable per key in bits 7..0.
// R03 - A falling edge on a key sets its status bit to 1.
// R04 - Reading the key status register clears its flags.
// R05 - A set key flag with its enable at 1 raises the key request.
// R06 - The key request also serves as a standby wake-up source.
// R07 - Software enables the key port input path before using key interrupts.
// R08 - Software never reads key status with read-modify-write instructions.
// R09 - Three external inputs each give an independent request line.
// R10 - External enables sit in bits 7..5, highest input at bit 7.
// R11 - Software always writes 0 to enable register bit 4.
// R12 - Bits 3..1 of the enable register clear flags on 0 and read as 1.
// R13 - The external flag register holds edge flags in bits 3..1.
// R14 - An external edge sets its flag; a request leaves only when enabled.
// R15 - External requests also serve as standby wake-up sources.
// R16 - Software clears an external flag before enabling its input.
// R17 - Requests are levels of flag and enable; flags stay until cleared.
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module edge_irq_unit
  import edge_irq_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [key_count-1:0] key_input_pins,
  input wire logic [ext_count-1:0] ext_irq_inputs,
  input wire logic [addr_w-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic key_irq_req,
  output logic [ext_count-1:0] ext_irq_req,
  output logic wake_req,
  output logic irq
);
  typedef struct packed {
    logic [key_count-1:0] key_enable_bits;
    logic [ext_count-1:0] ext_irq_enable_bits;
    logic test_ctl;
    logic [1:0] ev_status;
    logic [1:0] ev_mask;
    logic [7:0] rdata;
    irq_out_t out;
  } unit_state_t;

  unit_state_t st_q;
  unit_state_t st_d;

  reg_req_t req;
  logic [key_count-1:0] key_fall;
  logic [ext_count-1:0] ext_fall;
  logic [key_count-1:0] key_edge_flags;
  logic [ext_count-1:0] ext_request_flags;
  logic [key_count-1:0] key_clr;
  logic [ext_count-1:0] ext_clr;
  logic rd_ev_status;

  function automatic logic hit(input reg_req_t r, input logic [3:0] off);
    hit = (r.addr == off);
  endfunction

  // next flag value; an edge in the clearing cycle wins
  function automatic logic [key_count-1:0] key_next(
    input logic [key_count-1:0] cur,
    input logic [key_count-1:0] clr,
    input logic [key_count-1:0] set
  );
    key_next = (cur & ~clr) | set;
  endfunction

  function automatic logic [ext_count-1:0] ext_next(
    input logic [ext_count-1:0] cur,
    input logic [ext_count-1:0] clr,
    input logic [ext_count-1:0] set
  );
    ext_next = (cur & ~clr) | set;
  endfunction

  function automatic logic key_any(
    input logic [key_count-1:0] flags,
    input logic [key_count-1:0] en
  );
    key_any = |(flags & en);
  endfunction

  function automatic logic ext_any(
    input logic [ext_count-1:0] flags,
    input logic [ext_count-1:0] en
  );
    ext_any = |(flags & en);
  endfunction

  function automatic logic [ext_count-1:0] ext_level(
    input logic [ext_count-1:0] flags,
    input logic [ext_count-1:0] en
  );
    ext_level = flags & en;
  endfunction

  // clear strobes keep no state, so they always read as ones
  function automatic logic [7:0] enable_view(
    input logic [ext_count-1:0] en,
    input logic test
  );
    enable_view = {en, test, 3'h7, 1'b0};
  endfunction

  // unused upper bits and the test bit read as zero
  function automatic logic [7:0] flag_view(
    input logic [ext_count-1:0] flags
  );
    flag_view = {4'h0, flags, 1'b0};
  endfunction

  function automatic logic [7:0] summary_view(
    input logic [1:0] bits
  );
    summary_view = {6'h00, bits};
  endfunction

  // a read clears the summary, an event in the same cycle survives
  function automatic logic [1:0] status_next(
    input logic [1:0] cur,
    input logic rd_clr,
    input logic [1:0] set
  );
    status_next = (rd_clr ? 2'h0 : cur) | set;
  endfunction

  function automatic logic irq_level(
    input logic [1:0] status,
    input logic [1:0] mask
  );
    irq_level = |(status & mask);
  endfunction

  // decoded strobes shared by the flag clears
  logic rd_key_st;
  logic wr_ext_ctl;

  assign rd_key_st = req.rd && hit(req, key_edge_status_off);
  assign wr_ext_ctl = req.wr && hit(req, ext_irq_enable_clear_off);

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  fall_detect #(.width(key_count)) u_key_fall ( // R01
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pin(key_input_pins),
    .fall(key_fall)
  );

  fall_detect #(.width(ext_count)) u_ext_fall ( // R09
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pin(ext_irq_inputs),
    .fall(ext_fall)
  );

  // read side effect; software must not use bit ops here
  assign key_clr = {key_count{rd_key_st}}; // R04

  // clear strobes act on written zeros only
  assign ext_clr = wr_ext_ctl ?
    ~req.wdata[ext_clr_lsb +: ext_count] : '0; // R12

  assign rd_ev_status = req.rd && hit(req, irq_status_off);

  flag_bank #(.width(key_count)) u_key_flags ( // R03
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .set(key_fall),
    .clr(key_clr),
    .flags(key_edge_flags)
  );

  flag_bank #(.width(ext_count)) u_ext_flags ( // R14
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .set(ext_fall),
    .clr(ext_clr),
    .flags(ext_request_flags)
  );

  always_comb begin
    logic [key_count-1:0] key_flags_n;
    logic [ext_count-1:0] ext_flags_n;
    logic [1:0] ev_set;
    key_flags_n = '0;
    ext_flags_n = '0;
    ev_set = '0;
    st_d = st_q;

    // read-only and unmapped indices ignore writes
    if (req.wr) begin
      unique case (req.addr)
        key_input_enable_off: begin
          st_d.key_enable_bits = req.wdata; // R02
        end
        key_edge_status_off: begin
          st_d.key_enable_bits = st_q.key_enable_bits;
        end
        ext_irq_enable_clear_off: begin
          st_d.ext_irq_enable_bits =
            req.wdata[ext_en_lsb +: ext_count]; // R10
          // held only for readback; it steers nothing
          st_d.test_ctl = req.wdata[ext_test_bit];
        end
        ext_irq_flags_off: begin
          st_d.ext_irq_enable_bits = st_q.ext_irq_enable_bits;
        end
        irq_status_off: begin
          st_d.ev_status = st_q.ev_status;
        end
        irq_mask_off: begin
          st_d.ev_mask = req.wdata[1:0];
        end
        default: begin
        end
      endcase
    end

    // read data stand for one cycle and are zero otherwise
    st_d.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        key_input_enable_off: begin
          st_d.rdata = st_q.key_enable_bits;
        end
        key_edge_status_off: begin
          st_d.rdata = key_edge_flags; // R03
        end
        ext_irq_enable_clear_off: begin
          st_d.rdata = enable_view(st_q.ext_irq_enable_bits,
            st_q.test_ctl); // R12
        end
        ext_irq_flags_off: begin
          st_d.rdata = flag_view(ext_request_flags); // R13
        end
        irq_status_off: begin
          st_d.rdata = summary_view(st_q.ev_status);
        end
        irq_mask_off: begin
          st_d.rdata = summary_view(st_q.ev_mask);
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end

    // flags as they stand after this cycle
    key_flags_n = key_next(key_edge_flags, key_clr, key_fall);
    ext_flags_n = ext_next(ext_request_flags, ext_clr, ext_fall);

    // level requests follow flag and enable, not the edge itself
    st_d.out.key_req =
      key_any(key_flags_n, st_d.key_enable_bits); // R05 R17
    st_d.out.ext_req =
      ext_level(ext_flags_n, st_d.ext_irq_enable_bits); // R14 R17
    st_d.out.wake = st_d.out.key_req |
      ext_any(ext_flags_n, st_d.ext_irq_enable_bits); // R06 R15

    // summary events count only edges that arrive while enabled
    ev_set[ev_key] = key_any(key_fall, st_d.key_enable_bits);
    ev_set[ev_ext] = ext_any(ext_fall, st_d.ext_irq_enable_bits);
    st_d.ev_status = status_next(st_q.ev_status, rd_ev_status, ev_set);
    st_d.out.irq = irq_level(st_d.ev_status, st_d.ev_mask);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q.key_enable_bits <= key_enable_rst;
      st_q.ext_irq_enable_bits <= ext_enable_rst;
      st_q.test_ctl <= 1'b0;
      st_q.ev_status <= 2'h0;
      st_q.ev_mask <= irq_mask_rst;
      st_q.rdata <= 8'h00;
      st_q.out.key_req <= 1'b0;
      st_q.out.ext_req <= '0;
      st_q.out.wake <= 1'b0;
      st_q.out.irq <= 1'b0;
    end else if (ce) begin
      // a low enable freezes every field, outputs included
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign key_irq_req = st_q.out.key_req;
  assign ext_irq_req = st_q.out.ext_req; // R09
  assign wake_req = st_q.out.wake;
  assign irq = st_q.out.irq;
endmodule

// ===== testbench/edge_irq_monitor.sv
// port assertions of the edge interrupt unit
`timescale 1ns/1ps
module edge_irq_monitor
  import edge_irq_pkg::*;
(
  input logic mclk,
  input logic sys_rst,
  input logic ce,
  input logic [key_count-1:0] key_input_pins,
  input logic [ext_count-1:0] ext_irq_inputs,
  input logic [addr_w-1:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic key_irq_req,
  input logic [ext_count-1:0] ext_irq_req,
  input logic wake_req,
  input logic irq
);
  logic [key_count-1:0] kp_q;
  logic [ext_count-1:0] ep_q, e1_q, e2_q, e3_q, ef, eq;
  logic [2:0] kh_q;
  logic kf, ew;
  // detection is pipelined, so recent falls excuse a request
  assign kf = |(kp_q & ~key_input_pins);
  assign ef = ep_q & ~ext_irq_inputs;
  assign eq = ef | e1_q | e2_q | e3_q;
  assign ew = ce && reg_wr && reg_addr == ext_irq_enable_clear_off;
  always_ff @(posedge mclk) begin
    kp_q <= sys_rst ? '1 : key_input_pins;
    ep_q <= sys_rst ? '1 : ext_irq_inputs;
    kh_q <= sys_rst ? '0 : {kh_q[1:0], kf};
    {e3_q, e2_q, e1_q} <= sys_rst ? '0 : {e2_q, e1_q, ef};
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence key_rd_s;
    ce && reg_rd && reg_addr == key_edge_status_off;
  endsequence
  wake_src_a: assert property (
    wake_req == (key_irq_req || |ext_irq_req)) else $error("wake wrong");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray rdata");
  key_clear_a: assert property (
    key_rd_s ##0 (!kf && kh_q == 3'h0) |=> !key_irq_req)
    else $error("key req kept");
  key_rise_a: assert property (
    $rose(key_irq_req) |-> kh_q != 3'h0 || $past(reg_wr) || $past(reg_wr, 2))
    else $error("key req without edge");
  irq_mask_a: assert property (
    ce && reg_wr && reg_addr == irq_mask_off && reg_wdata[1:0] == 2'h0
    |=> !irq) else $error("masked irq high");
  for (genvar i = 0; i < ext_count; i++) begin : g_ext
    ext_rise_a: assert property (
      $rose(ext_irq_req[i]) |-> eq[i] || $past(ew) || $past(ew, 2))
      else $error("ext req without edge");
    ext_hold_a: assert property (
      ext_irq_req[i] && !ew && !$past(ew) |=> ext_irq_req[i])
      else $error("ext req dropped");
    ext_clear_a: assert property (
      ew && !reg_wdata[ext_clr_lsb + i] && !eq[i] |=> !ext_irq_req[i])
      else $error("ext flag kept");
  end
endmodule
bind edge_irq_unit edge_irq_monitor mon (.*);

// ===== testbench/pin_model.sv
// key switch and external pin model
`timescale 1ns/1ps
module pin_model (
  input logic mclk,
  input logic [7:0] kdn,
  input logic [2:0] edn,
  output logic [7:0] kpin,
  output logic [2:0] epin
);
  // pulled up; a press pulls a pin low one cycle later, for as long as it is held
  initial {kpin, epin} = '1;
  always @(posedge mclk) {kpin, epin} <= ~{kdn, edn};
endmodule

// ===== testbench/external_edge_interrupt_unit_test.sv
// bench of the edge interrupt unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
module external_edge_interrupt_unit_test;
  import edge_irq_pkg::*;
  logic mclk = 0, sys_rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, rd_q = 0;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, kdn = 0, key_input_pins, en, k, xe;
  logic [2:0] edn = 0, ext_irq_inputs, ext_irq_req, ee;
  logic key_irq_req, wake_req, irq;
  logic [7:0] exq[$];
  logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h0e, 8'h00, 8'h00, 8'h00, 8'h00};
  int error_cnt = 0, cmp_count = 0, seed = 57354;
  initial forever #10 mclk = ~mclk;
  pin_model pm (.mclk(mclk), .kdn(kdn), .edn(edn), .kpin(key_input_pins),
    .epin(ext_irq_inputs));
  edge_irq_unit dut (.*);
  task automatic cyc(int n = 1);
    repeat (n) @(posedge mclk);
  endtask
  task automatic acc(logic w, logic [3:0] a, logic [7:0] d);
    if (!w) exq.push_back(d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    cyc();
    reg_wr <= 0;
    reg_rd <= 0;
    cyc();
  endtask
  task automatic fall(logic [7:0] kf, logic [2:0] ef);
    kdn <= kf;
    edn <= ef;
    cyc();
    kdn <= 0;
    edn <= 0;
    cyc(4);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    rd_q <= reg_rd;
    if (rd_q) begin
      xe = exq.pop_front();
      `CHK("rdata", xe, reg_rdata)
    end
  end
  initial begin
    cyc(2);
    sys_rst <= 0;
    foreach (rv[i]) acc(0, 4'(i), rv[i]);
    $display("reset test done");
    acc(1, irq_mask_off, 8'h03);
    acc(0, irq_mask_off, 8'h03);
    repeat (4) begin
      en = 8'($random(seed));
      k = 8'($random(seed));
      acc(1, key_input_enable_off, en);
      acc(0, key_input_enable_off, en);
      fall(k, 3'h0);
      `CHK("key_req", |(k & en), key_irq_req)
      `CHK("wake", |(k & en), wake_req)
      `CHK("irq", |(k & en), irq)
      acc(0, key_edge_status_off, k);
      acc(0, key_edge_status_off, 8'h00);
      `CHK("key_req", 1'b0, key_irq_req)
      acc(0, irq_status_off, {7'h00, |(k & en)});
      `CHK("irq", 1'b0, irq)
    end
    $display("key test done");
    acc(1, key_input_enable_off, 8'hff);
    ce <= 0;
    fall(8'hff, 3'h0);
    ce <= 1;
    cyc();
    `CHK("key_req", 1'b0, key_irq_req)
    acc(0, key_edge_status_off, 8'h00);
    $display("clock enable test done");
    ee = 3'($random(seed)) | 3'h1;
    acc(1, ext_irq_enable_clear_off, 8'h00);
    fall(8'h00, 3'h7);
    acc(0, ext_irq_flags_off, 8'h0e);
    `CHK("ext_req", 3'h0, ext_irq_req)
    acc(1, ext_irq_enable_clear_off, {ee, 5'h0e});
    `CHK("ext_req", ee, ext_irq_req)
    `CHK("wake", 1'b1, wake_req)
    acc(0, ext_irq_enable_clear_off, {ee, 5'h0e});
    acc(1, ext_irq_enable_clear_off, {ee, 5'h0c});
    `CHK("ext_req", ee & 3'h6, ext_irq_req)
    acc(0, ext_irq_flags_off, 8'h0c);
    fall(8'h00, 3'h1);
    `CHK("irq", 1'b1, irq)
    acc(1, irq_mask_off, 8'h00);
    `CHK("irq", 1'b0, irq)
    acc(1, irq_mask_off, 8'h03);
    acc(0, irq_status_off, 8'h02);
    `CHK("irq", 1'b0, irq)
    $display("ext test done");
    conclude();
  end
  initial begin
    cyc(3000);
    error_cnt++;
    conclude();
  end
endmodule
